// >>> design/bcm_pkg.sv
/*
 * bcm_pkg: register map, field positions, reset values and timing
 * constants of the two-breaker control and status monitor.
 * Assumes a 32-bit classic Wishbone bus, byte addresses, 10 MHz clock.
 */
package bcm_pkg;

    // clock
    localparam int unsigned CLK_HZ = 10_000_000;

    // register byte offsets, one aligned word each
    localparam logic [7:0] OFF_CTRL0  = 8'h00;
    localparam logic [7:0] OFF_CTRL1  = 8'h04;
    localparam logic [7:0] OFF_DLY0   = 8'h08;
    localparam logic [7:0] OFF_DLY1   = 8'h0c;
    localparam logic [7:0] OFF_HOLD0  = 8'h10;
    localparam logic [7:0] OFF_HOLD1  = 8'h14;
    localparam logic [7:0] OFF_NAMELO0 = 8'h18;
    localparam logic [7:0] OFF_NAMEHI0 = 8'h1c;
    localparam logic [7:0] OFF_NAMELO1 = 8'h20;
    localparam logic [7:0] OFF_NAMEHI1 = 8'h24;
    localparam logic [7:0] OFF_STAT   = 8'h28;
    localparam logic [7:0] OFF_IRQ    = 8'h2c;
    localparam logic [7:0] OFF_MASK   = 8'h30;
    localparam logic [7:0] OFF_CMD    = 8'h34;

    // control register fields (per breaker)
    localparam int unsigned CTL_ENABLE = 0;
    localparam int unsigned CTL_BUTTON = 1;
    localparam int unsigned CTL_MODE1P = 2;

    // command register fields, breaker n at bit n*CMD_STRIDE
    localparam int unsigned CMD_OPEN   = 0;
    localparam int unsigned CMD_CLOSE  = 1;
    localparam int unsigned CMD_STRIDE = 2;

    // status register fields, breaker n at bit n*STAT_STRIDE
    localparam int unsigned ST_CLOSED  = 0;
    localparam int unsigned ST_POLE_A  = 1;
    localparam int unsigned ST_POLE_B  = 2;
    localparam int unsigned ST_POLE_C  = 3;
    localparam int unsigned ST_DISAGR  = 4;
    localparam int unsigned ST_ALARM   = 5;
    localparam int unsigned ST_OOS     = 6;
    localparam int unsigned ST_HOLD    = 7;
    localparam int unsigned STAT_STRIDE = 8;

    // interrupt event fields, breaker n at bit n*IRQ_STRIDE
    localparam int unsigned EV_DISAGR  = 0;
    localparam int unsigned EV_ALARM   = 1;
    localparam int unsigned EV_OOS     = 2;
    localparam int unsigned EV_MOVE    = 3;
    localparam int unsigned IRQ_STRIDE = 4;

    // reset values
    localparam logic [2:0]  CTRL_RST = 3'h0;
    localparam logic [15:0] DLY_RST  = 16'h0064;
    localparam logic [15:0] HOLD_RST = 16'h0064;

    // delay and hold settings count in milliseconds
    localparam int unsigned MS_UNIT_US   = 1000;
    localparam int unsigned TICK_CYCLES  = (CLK_HZ / 1_000_000) * MS_UNIT_US;

endpackage : bcm_pkg

// >>> design/bcm_top.sv
/*
 * bcm_top: two independent breaker control and status monitors with a
 * classic Wishbone register slave and a level interrupt.
 * Assumes contact inputs arrive asynchronously and are synchronised here;
 * open/close outputs drive output relays directly.
 */
// Added by the designer: the register addresses and the Wishbone register port.
`timescale 1ns/1ns

module bcm_top #(
    parameter int unsigned NUM_BRK = 2,
    parameter int unsigned TICK    = bcm_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    // wishbone slave
    input  wire logic               cyc_i,
    input  wire logic               stb_i,
    input  wire logic               we_i,
    input  wire logic [7:0]         adr_i,
    input  wire logic [3:0]         sel_i,
    input  wire logic [31:0]        dat_i,
    output logic      [31:0]        dat_o,
    output logic                    ack_o,
    // contact and operand inputs, asynchronous
    input  wire logic [NUM_BRK-1:0] pos_a_i,
    input  wire logic [NUM_BRK-1:0] pos_b_i,
    input  wire logic [NUM_BRK-1:0] pos_c_i,
    input  wire logic [NUM_BRK-1:0] external_alarm_input_i,
    input  wire logic [NUM_BRK-1:0] out_of_service_input_i,
    input  wire logic [NUM_BRK-1:0] local_control_status_source_i,
    input  wire logic [NUM_BRK-1:0] trip_operand_i,
    input  wire logic [NUM_BRK-1:0] close_operand_i,
    input  wire logic [NUM_BRK-1:0] button_open_i,
    input  wire logic [NUM_BRK-1:0] button_close_i,
    // relay drives and indications
    output logic      [NUM_BRK-1:0] open_relay_o,
    output logic      [NUM_BRK-1:0] close_relay_o,
    output logic      [NUM_BRK-1:0] local_control_o,
    output logic                    irq_o
);

    ////////////////////////////////////////////////////////////////////////
    // parameter checks

    initial begin
        if (NUM_BRK != 2) begin
            $error("bcm_top: exactly two breaker instances are supported");
        end
        if (TICK < 1) begin
            $error("bcm_top: TICK must be at least one cycle");
        end
    end

    localparam int unsigned NIN = 10;  // synchronised input groups

    typedef struct packed {
        logic [NIN*NUM_BRK-1:0] sync1;
        logic [NIN*NUM_BRK-1:0] sync2;
        logic [NUM_BRK-1:0][2:0]  ctrl;
        logic [NUM_BRK-1:0][15:0] dly;
        logic [NUM_BRK-1:0][15:0] hold;
        logic [NUM_BRK-1:0][47:0] name;
        logic [NUM_BRK-1:0][15:0] dly_cnt;
        logic [NUM_BRK-1:0][15:0] hold_cnt;
        logic [NUM_BRK-1:0]       disagr;
        logic [NUM_BRK-1:0]       alarm;
        logic [NUM_BRK-1:0]       oos;
        logic [NUM_BRK-1:0]       closed;
        logic [NUM_BRK-1:0]       open_r;
        logic [NUM_BRK-1:0]       close_r;
        logic [NUM_BRK-1:0]       loc;
        logic [NUM_BRK*4-1:0]     irq_st;
        logic [NUM_BRK*4-1:0]     irq_msk;
        logic [31:0]              tick_cnt;
        logic                     tick;
        logic [31:0]              rdata;
        logic                     ack;
    } bcm_state_t;

    bcm_state_t s_q;
    bcm_state_t s_d;

    // synchronised views, second flop only
    logic [NUM_BRK-1:0] pa, pb, pc, ext, oos_in, loc_in, trp, cls, bo, bc;
    assign {bc, bo, cls, trp, loc_in, oos_in, ext, pc, pb, pa} = s_q.sync2;

    logic acc;
    assign acc = cyc_i & stb_i & ~s_q.ack;

    ////////////////////////////////////////////////////////////////////////
    // next-state logic

    always_comb begin
        logic [NUM_BRK*4-1:0] ev;
        logic [NUM_BRK-1:0]   sw_open;
        logic [NUM_BRK-1:0]   sw_close;
        logic [31:0]          wmask;
        logic [31:0]          rd;
        logic [31:0]          st;
        logic                 en;
        logic                 m1p;
        logic                 mismatch;
        logic                 man_close;
        logic [2:0]           phs;
        ev        = '0;
        sw_open   = '0;
        sw_close  = '0;
        rd        = '0;
        st        = '0;
        en        = 1'b0;
        m1p       = 1'b0;
        mismatch  = 1'b0;
        man_close = 1'b0;
        phs       = '0;
        wmask     = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
        s_d       = s_q;

        // two-flop synchroniser for all contact and operand inputs
        s_d.sync1 = {button_close_i, button_open_i, close_operand_i, trip_operand_i,
                     local_control_status_source_i, out_of_service_input_i,
                     external_alarm_input_i, pos_c_i, pos_b_i, pos_a_i};
        s_d.sync2 = s_q.sync1;

        // millisecond tick shared by both timers
        s_d.tick = 1'b0;
        if (s_q.tick_cnt >= TICK - 1) begin
            s_d.tick_cnt = '0;
            s_d.tick     = 1'b1;
        end else begin
            s_d.tick_cnt = s_q.tick_cnt + 32'h1;
        end

        // software command pulses, write-only register
        if (acc && we_i && adr_i == bcm_pkg::OFF_CMD) begin
            for (int n = 0; n < NUM_BRK; n++) begin
                sw_open[n]  = dat_i[n*bcm_pkg::CMD_STRIDE + bcm_pkg::CMD_OPEN];
                sw_close[n] = dat_i[n*bcm_pkg::CMD_STRIDE + bcm_pkg::CMD_CLOSE];
            end
        end

        // per-breaker logic, identical for each instance
        for (int n = 0; n < NUM_BRK; n++) begin
            en  = s_q.ctrl[n][bcm_pkg::CTL_ENABLE];
            m1p = s_q.ctrl[n][bcm_pkg::CTL_MODE1P];
            // positions are high when closed, low when open
            phs = m1p ? {pc[n], pb[n], pa[n]} : {3{pa[n]}};
            mismatch = en & m1p & ~(&phs == |phs);
            s_d.closed[n] = en & (&phs);
            // manual close: panel button if allowed, or software command
            man_close = en & ((bc[n] & s_q.ctrl[n][bcm_pkg::CTL_BUTTON]) | sw_close[n]);
            s_d.open_r[n]  = en & (trp[n] | sw_open[n]
                           | (bo[n] & s_q.ctrl[n][bcm_pkg::CTL_BUTTON]));
            s_d.close_r[n] = en & (cls[n] | man_close);
            s_d.alarm[n]   = en & ext[n];
            s_d.oos[n]     = en & oos_in[n];
            s_d.loc[n]     = en & loc_in[n];

            // disagreement timer, restarted on agreement
            if (!mismatch) begin
                s_d.dly_cnt[n] = '0;
                s_d.disagr[n]  = 1'b0;
            end else if (s_q.dly_cnt[n] >= s_q.dly[n]) begin
                s_d.disagr[n]  = 1'b1;
            end else if (s_q.tick) begin
                s_d.dly_cnt[n] = s_q.dly_cnt[n] + 16'h1;
            end

            // manual close hold window
            if (man_close) begin
                s_d.hold_cnt[n] = s_q.hold[n];
            end else if (!en) begin
                s_d.hold_cnt[n] = '0;
            end else if (s_q.tick && s_q.hold_cnt[n] != 16'h0) begin
                s_d.hold_cnt[n] = s_q.hold_cnt[n] - 16'h1;
            end

            // rising-edge events, move event on either edge
            ev[n*bcm_pkg::IRQ_STRIDE + bcm_pkg::EV_DISAGR] = s_d.disagr[n] & ~s_q.disagr[n];
            ev[n*bcm_pkg::IRQ_STRIDE + bcm_pkg::EV_ALARM]  = s_d.alarm[n] & ~s_q.alarm[n];
            ev[n*bcm_pkg::IRQ_STRIDE + bcm_pkg::EV_OOS]    = s_d.oos[n] & ~s_q.oos[n];
            ev[n*bcm_pkg::IRQ_STRIDE + bcm_pkg::EV_MOVE]   = s_d.closed[n] ^ s_q.closed[n];

            // status word
            st[n*bcm_pkg::STAT_STRIDE + bcm_pkg::ST_CLOSED] = s_q.closed[n];
            st[n*bcm_pkg::STAT_STRIDE + bcm_pkg::ST_POLE_A] = phs[0];
            st[n*bcm_pkg::STAT_STRIDE + bcm_pkg::ST_POLE_B] = phs[1];
            st[n*bcm_pkg::STAT_STRIDE + bcm_pkg::ST_POLE_C] = phs[2];
            st[n*bcm_pkg::STAT_STRIDE + bcm_pkg::ST_DISAGR] = s_q.disagr[n];
            st[n*bcm_pkg::STAT_STRIDE + bcm_pkg::ST_ALARM]  = s_q.alarm[n];
            st[n*bcm_pkg::STAT_STRIDE + bcm_pkg::ST_OOS]    = s_q.oos[n];
            st[n*bcm_pkg::STAT_STRIDE + bcm_pkg::ST_HOLD]   = s_q.hold_cnt[n] != 16'h0;
        end

        // register writes; write-one-to-clear loses to a new event
        if (acc && we_i) begin
            unique case (adr_i)
                bcm_pkg::OFF_CTRL0:   s_d.ctrl[0] = (s_q.ctrl[0] & ~wmask[2:0]) | (dat_i[2:0] & wmask[2:0]);
                bcm_pkg::OFF_CTRL1:   s_d.ctrl[1] = (s_q.ctrl[1] & ~wmask[2:0]) | (dat_i[2:0] & wmask[2:0]);
                bcm_pkg::OFF_DLY0:    s_d.dly[0]  = (s_q.dly[0] & ~wmask[15:0]) | (dat_i[15:0] & wmask[15:0]);
                bcm_pkg::OFF_DLY1:    s_d.dly[1]  = (s_q.dly[1] & ~wmask[15:0]) | (dat_i[15:0] & wmask[15:0]);
                bcm_pkg::OFF_HOLD0:   s_d.hold[0] = (s_q.hold[0] & ~wmask[15:0]) | (dat_i[15:0] & wmask[15:0]);
                bcm_pkg::OFF_HOLD1:   s_d.hold[1] = (s_q.hold[1] & ~wmask[15:0]) | (dat_i[15:0] & wmask[15:0]);
                // six-character label, four bytes low, two bytes high
                bcm_pkg::OFF_NAMELO0: s_d.name[0][31:0]  = (s_q.name[0][31:0] & ~wmask) | (dat_i & wmask);
                bcm_pkg::OFF_NAMEHI0: s_d.name[0][47:32] = (s_q.name[0][47:32] & ~wmask[15:0])
                                                         | (dat_i[15:0] & wmask[15:0]);
                bcm_pkg::OFF_NAMELO1: s_d.name[1][31:0]  = (s_q.name[1][31:0] & ~wmask) | (dat_i & wmask);
                bcm_pkg::OFF_NAMEHI1: s_d.name[1][47:32] = (s_q.name[1][47:32] & ~wmask[15:0])
                                                         | (dat_i[15:0] & wmask[15:0]);
                bcm_pkg::OFF_IRQ:     s_d.irq_st  = s_q.irq_st & ~(dat_i[NUM_BRK*4-1:0] & wmask[NUM_BRK*4-1:0]);
                bcm_pkg::OFF_MASK:    s_d.irq_msk = (s_q.irq_msk & ~wmask[NUM_BRK*4-1:0])
                                                  | (dat_i[NUM_BRK*4-1:0] & wmask[NUM_BRK*4-1:0]);
                default: ;
            endcase
        end
        s_d.irq_st = s_d.irq_st | ev;   // set beats clear

        // read mux, unmapped addresses read zero
        unique case (adr_i)
            bcm_pkg::OFF_CTRL0:   rd = {29'h0, s_q.ctrl[0]};
            bcm_pkg::OFF_CTRL1:   rd = {29'h0, s_q.ctrl[1]};
            bcm_pkg::OFF_DLY0:    rd = {16'h0, s_q.dly[0]};
            bcm_pkg::OFF_DLY1:    rd = {16'h0, s_q.dly[1]};
            bcm_pkg::OFF_HOLD0:   rd = {16'h0, s_q.hold[0]};
            bcm_pkg::OFF_HOLD1:   rd = {16'h0, s_q.hold[1]};
            bcm_pkg::OFF_NAMELO0: rd = s_q.name[0][31:0];
            bcm_pkg::OFF_NAMEHI0: rd = {16'h0, s_q.name[0][47:32]};
            bcm_pkg::OFF_NAMELO1: rd = s_q.name[1][31:0];
            bcm_pkg::OFF_NAMEHI1: rd = {16'h0, s_q.name[1][47:32]};
            bcm_pkg::OFF_STAT:    rd = st;
            bcm_pkg::OFF_IRQ:     rd = {24'h0, s_q.irq_st};
            bcm_pkg::OFF_MASK:    rd = {24'h0, s_q.irq_msk};
            default:              rd = 32'h0;
        endcase
        s_d.rdata = acc ? rd : s_q.rdata;
        s_d.ack   = acc;   // one wait state, dropped the cycle after

        if (rst_i) begin
            s_d          = '0;
            s_d.ctrl     = {NUM_BRK{bcm_pkg::CTRL_RST}};
            s_d.dly      = {NUM_BRK{bcm_pkg::DLY_RST}};
            s_d.hold     = {NUM_BRK{bcm_pkg::HOLD_RST}};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clk_i) begin
        s_q <= s_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all from flops except the irq reduction

    assign dat_o           = s_q.rdata;
    assign ack_o           = s_q.ack;
    assign open_relay_o    = s_q.open_r;
    assign close_relay_o   = s_q.close_r;
    assign local_control_o = s_q.loc;
    assign irq_o           = |(s_q.irq_st & s_q.irq_msk);

endmodule : bcm_top

// >>> testbench/bcm_properties.sv
/* bcm_properties: port-level checks of the breaker monitor, bound to bcm_top.
   Assumes one clock, sync active-high reset, full-word register writes. */
`timescale 1ns/1ns
module bcm_properties #(
    parameter int unsigned NUM_BRK = 2
) (
    // clock, reset and bus
    input wire logic               clk_i,
    input wire logic               rst_i,
    input wire logic               cyc_i,
    input wire logic               stb_i,
    input wire logic               we_i,
    input wire logic [7:0]         adr_i,
    input wire logic [31:0]        dat_i,
    input wire logic [31:0]        dat_o,
    input wire logic               ack_o,
    // operands and outputs
    input wire logic [NUM_BRK-1:0] trip_operand_i,
    input wire logic [NUM_BRK-1:0] close_operand_i,
    input wire logic [NUM_BRK-1:0] local_control_status_source_i,
    input wire logic [NUM_BRK-1:0] open_relay_o,
    input wire logic [NUM_BRK-1:0] close_relay_o,
    input wire logic [NUM_BRK-1:0] local_control_o,
    input wire logic               irq_o
);
    logic [2:0]  ctl_q;                                     // breaker zero control shadow
    logic [31:0] msk_q;                                     // interrupt mask shadow
    wire         wr_go = cyc_i && stb_i && we_i && !ack_o;
    wire         cmd_go = wr_go && adr_i == bcm_pkg::OFF_CMD;

    // shadows move at the edge that takes the write, like the design
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_q <= 3'h0;
            msk_q <= 32'h0;
        end else if (wr_go && adr_i == bcm_pkg::OFF_CTRL0) begin
            ctl_q <= dat_i[2:0];
        end else if (wr_go && adr_i == bcm_pkg::OFF_MASK) begin
            msk_q <= dat_i;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ////////////////////////////////////////////////////////////////////////////
    // four samples cover the two-flop sync plus the output register
    sequence s_take;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_trip_on;
        (ctl_q[0] && trip_operand_i[0]) [*4];
    endsequence
    sequence s_close_on;
        (ctl_q[0] && close_operand_i[0]) [*4];
    endsequence

    a_ack_follows: assert property (s_take |=> ack_o) else $error("ack missing after request");
    a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
    a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
    a_unmapped_zero: assert property (s_take and (!we_i && adr_i >= 8'h38) |=> dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_trip_drives: assert property (s_trip_on |-> open_relay_o[0])
        else $error("open relay not driven");
    a_close_drives: assert property (s_close_on |-> close_relay_o[0])
        else $error("close relay not driven");
    a_local_low: assert property ((!local_control_status_source_i[0]) [*4] |-> !local_control_o[0])
        else $error("local control without source");
    a_disabled_idle: assert property ((!ctl_q[0]) [*4] |-> !(open_relay_o[0] || close_relay_o[0] || local_control_o[0]))
        else $error("disabled breaker active");
    a_button_gate: assert property ((!ctl_q[1] && !close_operand_i[0] && !cmd_go) [*4] |-> !close_relay_o[0])
        else $error("close relay while buttons off");
    a_irq_masked: assert property (irq_o |-> msk_q != 32'h0) else $error("irq with empty mask");
    a_reset_idle: assert property ($fell(rst_i) |-> !ack_o && !irq_o && open_relay_o == '0)
        else $error("outputs active after reset");
endmodule : bcm_properties

bind bcm_top bcm_properties #(.NUM_BRK(NUM_BRK)) chk_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .dat_i, .dat_o, .ack_o, .trip_operand_i, .close_operand_i, .local_control_status_source_i,
    .open_relay_o, .close_relay_o, .local_control_o, .irq_o);

// >>> testbench/bcm_breaker_model.sv
/* bcm_breaker_model: behavioural breaker mechanism and auxiliary contacts.
   Assumes relay levels from the monitor; poles B and C may lag or stick. */
`timescale 1ns/1ns
module bcm_breaker_model #(
    parameter int unsigned NUM_BRK = 2
) (
    // clock and relay drives
    input  wire logic               clk_i,
    input  wire logic [NUM_BRK-1:0] open_i,
    input  wire logic [NUM_BRK-1:0] close_i,
    // faults commanded by the bench
    input  wire logic [NUM_BRK-1:0] stuck_bc_i,
    input  wire logic [7:0]         lag_i,
    // auxiliary contacts
    output logic      [NUM_BRK-1:0] pos_a_o,
    output logic      [NUM_BRK-1:0] pos_b_o,
    output logic      [NUM_BRK-1:0] pos_c_o
);
    logic [NUM_BRK-1:0] shut_q = '0;          // mechanism closed
    logic [7:0]         age_q [NUM_BRK] = '{default: 8'h0};

    // open coil wins over close coil, as on a real mechanism
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < NUM_BRK; i++) begin
            shut_q[i] <= open_i[i] ? 1'b0 : (close_i[i] ? 1'b1 : shut_q[i]);
            age_q[i] <= (open_i[i] || close_i[i]) ? 8'h0 : (age_q[i] == 8'hff ? 8'hff : age_q[i] + 8'h1);
        end
    end

    // every contact reads low while open; slow poles follow after the lag
    always_comb begin
        pos_a_o = shut_q;
        for (int i = 0; i < NUM_BRK; i++) begin
            pos_b_o[i] = shut_q[i] && age_q[i] >= lag_i && !stuck_bc_i[i];
            pos_c_o[i] = pos_b_o[i];
        end
    end
endmodule : bcm_breaker_model

// >>> testbench/test_breaker_control_status_monitor.sv
/* test_breaker_control_status_monitor: self-checking bench for bcm_top.
   Assumes the breaker model on the contact side and a 10 MHz clock. */
`timescale 1ns/1ns
module test_breaker_control_status_monitor;
    localparam int unsigned TK = 4;           // cycles per ms, shortened
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i = 1'b0;
    logic [7:0]  adr_i = 8'h00;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic        ack_o;
    logic        irq_o;
    logic [1:0]  pos_a_i, pos_b_i, pos_c_i, open_relay_o, close_relay_o, local_control_o;
    logic [1:0]  external_alarm_input_i = '0, out_of_service_input_i = '0, local_control_status_source_i = '0;
    logic [1:0]  trip_operand_i = '0, close_operand_i = '0, button_open_i = '0, button_close_i = '0;
    logic [1:0]  stuck = '0;
    logic [7:0]  lag = 8'h0;
    logic [31:0] r;
    int          miscompares = 0;
    int          total_checks = 0;

    bcm_top #(.NUM_BRK(2), .TICK(TK)) dut_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
        .dat_o, .ack_o, .pos_a_i, .pos_b_i, .pos_c_i, .external_alarm_input_i, .out_of_service_input_i,
        .local_control_status_source_i, .trip_operand_i, .close_operand_i, .button_open_i,
        .button_close_i, .open_relay_o, .close_relay_o, .local_control_o, .irq_o);
    bcm_breaker_model #(.NUM_BRK(2)) brk_u (.clk_i, .open_i(open_relay_o), .close_i(close_relay_o),
        .stuck_bc_i(stuck), .lag_i(lag), .pos_a_o(pos_a_i), .pos_b_o(pos_b_i), .pos_c_o(pos_c_i));

    initial forever #50 clk_i = ~clk_i;

    ////////////////////////////////////////////////////////////////////////////
    // expected status bit of a breaker field
    function automatic logic [31:0] fld(input int b, input int f, input logic on);
        return on ? (32'h1 << (b * bcm_pkg::STAT_STRIDE + f)) : 32'h0;
    endfunction : fld

    task automatic tk(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tk

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // one classic cycle; no wait limit, the watchdog ends a hang
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hf;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask : wr

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(nm, e & m, q & m);
    endtask : rdc

    // drive breaker zero open or shut, then let contacts settle
    task automatic poke(input logic shut);
        if (shut) close_operand_i[0] <= 1'b1;
        else trip_operand_i[0] <= 1'b1;
        tk(6);
        close_operand_i[0] <= 1'b0;
        trip_operand_i[0] <= 1'b0;
        tk(40);
    endtask : poke

    task automatic summarize();
        if (miscompares == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : summarize

    ////////////////////////////////////////////////////////////////////////////
    // watchdog: the whole sequence needs about five hundred cycles
    initial begin
        tk(20000);
        miscompares++;
        summarize();
    end

    initial begin
        r = $urandom(32'h5b4e);
        tk(10);
        rst_i <= 1'b0;
        tk(1);
        rdc("ctrl0", bcm_pkg::OFF_CTRL0, 32'h7, 32'h0);
        rdc("dly0", bcm_pkg::OFF_DLY0, 32'hffff, {16'h0, bcm_pkg::DLY_RST});
        rdc("hold1", bcm_pkg::OFF_HOLD1, 32'hffff, {16'h0, bcm_pkg::HOLD_RST});
        wr(8'h3c, 32'hffffffff);
        rdc("unmapped", 8'h3c, 32'hffffffff, 32'h0);
        wr(bcm_pkg::OFF_NAMELO1, 32'h4c4e3031);
        wr(bcm_pkg::OFF_NAMEHI1, 32'h00004142);
        rdc("name_lo", bcm_pkg::OFF_NAMELO1, 32'hffffffff, 32'h4c4e3031);
        rdc("name_hi", bcm_pkg::OFF_NAMEHI1, 32'hffff, 32'h4142);
        // second breaker alone; first two passes all high, enabled then not
        for (int i = 0; i < 12; i++) begin
            r = $urandom();
            if (i < 2) r[5:0] = {5'h1f, i == 0};
            wr(bcm_pkg::OFF_CTRL1, {31'h0, r[0]});
            trip_operand_i[1] <= r[1];
            close_operand_i[1] <= r[2];
            local_control_status_source_i[1] <= r[3];
            external_alarm_input_i[1] <= r[4];
            out_of_service_input_i[1] <= r[5];
            tk(5);
            chk("open1", {31'h0, r[0] & r[1]}, {31'h0, open_relay_o[1]});
            chk("close1", {31'h0, r[0] & r[2]}, {31'h0, close_relay_o[1]});
            chk("local1", {31'h0, r[0] & r[3]}, {31'h0, local_control_o[1]});
            rdc("stat1", bcm_pkg::OFF_STAT, 32'h6000,
                fld(1, bcm_pkg::ST_ALARM, r[0] & r[4]) | fld(1, bcm_pkg::ST_OOS, r[0] & r[5]));
        end
        // manual close hold, refused while panel buttons are off
        wr(bcm_pkg::OFF_HOLD0, 32'h3);
        for (int k = 1; k < 4; k += 2) begin
            wr(bcm_pkg::OFF_CTRL0, k);
            button_close_i[0] <= 1'b1;
            tk(3);
            button_close_i[0] <= 1'b0;
            tk(3);
            rdc("hold", bcm_pkg::OFF_STAT, 32'h80, fld(0, bcm_pkg::ST_HOLD, k == 3));
        end
        tk(40);
        rdc("hold_end", bcm_pkg::OFF_STAT, 32'h80, 32'h0);
        // single-pole tracking: a short lag is tolerated, a stuck pole is not
        local_control_status_source_i[0] <= 1'b1;
        wr(bcm_pkg::OFF_DLY0, 32'h4);   // four ms outlasts coil time plus the three-cycle lag
        wr(bcm_pkg::OFF_CTRL0, 32'h5);
        lag <= 8'h3;
        poke(1'b0);
        poke(1'b1);
        rdc("agree", bcm_pkg::OFF_STAT, 32'h11, 32'h01);
        rdc("lag_no_event", bcm_pkg::OFF_IRQ, 32'h1, 32'h0);
        chk("local0", 32'h1, {31'h0, local_control_o[0]});
        poke(1'b0);
        stuck[0] <= 1'b1;
        poke(1'b1);
        rdc("disagree", bcm_pkg::OFF_STAT, 32'h11, 32'h10);
        wr(bcm_pkg::OFF_CTRL0, 32'h1);
        tk(6);
        rdc("three_pole", bcm_pkg::OFF_STAT, 32'h11, 32'h01);
        // panel open button with buttons allowed, then a software close command
        wr(bcm_pkg::OFF_CTRL0, 32'h3);
        button_open_i[0] <= 1'b1;
        tk(4);
        chk("btn_open", 32'h1, {31'h0, open_relay_o[0]});
        button_open_i[0] <= 1'b0;
        tk(10);
        rdc("opened", bcm_pkg::OFF_STAT, 32'h1, 32'h0);
        wr(bcm_pkg::OFF_CMD, 32'h2);
        rdc("cmd_hold", bcm_pkg::OFF_STAT, 32'h80, 32'h80);
        // alarm event of breaker zero: raise, mask, unmask, clear
        wr(bcm_pkg::OFF_IRQ, 32'hff);
        wr(bcm_pkg::OFF_MASK, 32'h2);
        external_alarm_input_i[0] <= 1'b1;
        tk(5);
        chk("irq_set", 32'h1, {31'h0, irq_o});
        rdc("irq_flag", bcm_pkg::OFF_IRQ, 32'h2, 32'h2);
        wr(bcm_pkg::OFF_MASK, 32'h0);
        chk("irq_masked", 32'h0, {31'h0, irq_o});
        wr(bcm_pkg::OFF_MASK, 32'h2);
        chk("irq_unmasked", 32'h1, {31'h0, irq_o});
        wr(bcm_pkg::OFF_IRQ, 32'h2);
        chk("irq_clear", 32'h0, {31'h0, irq_o});
        summarize();
    end
endmodule : test_breaker_control_status_monitor
